//--- shared/cpp_pkg.sv
package cpp_pkg;
    // link timing of the host end
    localparam int          MCLK_NS       = 10;
    localparam int          QUARTER_NS    = 80;
    localparam int          QUARTER_CYC   = (QUARTER_NS + MCLK_NS - 1) / MCLK_NS;
    localparam logic [3:0]  QUARTER_LAST  = 4'(QUARTER_CYC - 1);

    // addresses on the link
    localparam logic [7:0]  SPI_CHIP_ADDR = 8'h9E;
    localparam logic [5:0]  I2C_ADDR_HI   = 6'h27;

    // device register space and pointer layout
    localparam int          REG_COUNT     = 32;
    localparam int          REG_AW        = 5;
    localparam int          PTR_STEP_BIT  = 7;
    localparam logic [6:0]  PTR_ONE       = 7'h01;
    localparam logic [4:0]  CFG1_ADDR     = 5'h03;
    localparam logic [4:0]  GLOBAL_ADDR   = 5'h05;
    localparam int          EN_BIT        = 0;

    // bit and byte counting
    localparam logic [3:0]  BIT_LAST_BYTE = 4'h7;
    localparam logic [3:0]  BIT_LAST_I2C  = 4'h8;
    localparam logic [1:0]  BYTE_ADDR     = 2'h0;
    localparam logic [1:0]  BYTE_PTR      = 2'h1;
    localparam logic [1:0]  BYTE_DATA     = 2'h2;
    localparam logic [1:0]  BYTE_READ     = 2'h3;

    // host command registers
    localparam logic [1:0]  HR_CTRL       = 2'h0;
    localparam logic [1:0]  HR_PTR        = 2'h1;
    localparam logic [1:0]  HR_DATA       = 2'h2;
    localparam logic [1:0]  HR_CMD        = 2'h3;
    localparam int          CTRL_SPI      = 0;
    localparam int          CTRL_STRAP    = 1;
    localparam int          CMD_WRITE     = 0;
    localparam int          CMD_READ      = 1;
    localparam int          STAT_BUSY     = 0;
    localparam int          STAT_NACK     = 1;

    typedef enum logic [5:0] {
        D_IDLE   = 6'h01,
        D_RECV   = 6'h02,
        D_ACK    = 6'h04,
        D_SEND   = 6'h08,
        D_HACK   = 6'h10,
        D_IGNORE = 6'h20
    } cpp_dev_state_t;

    typedef enum logic [3:0] {
        H_IDLE  = 4'h1,
        H_START = 4'h2,
        H_BIT   = 4'h4,
        H_STOP  = 4'h8
    } cpp_host_state_t;
endpackage

//--- shared/cpp_link_if.sv
interface cpp_link_if;
    logic address_select_strap;
    logic serial_bit_clock;
    logic host_data_out;
    logic host_data_oe;
    logic dev_data_out;
    logic dev_data_oe;
    logic serial_data_in;

    // open-drain wired-and, pulled high when nobody pulls low
    assign serial_data_in = ~((host_data_oe & ~host_data_out)
                            | (dev_data_oe & ~dev_data_out));

    modport dev (
        input  address_select_strap,
        input  serial_bit_clock,
        input  serial_data_in,
        output dev_data_out,
        output dev_data_oe
    );

    modport host (
        output address_select_strap,
        output serial_bit_clock,
        output host_data_out,
        output host_data_oe,
        input  serial_data_in
    );
endinterface

//--- core/cpp_device.sv
// Function
// - strap falling edge selects write-only serial mode
// - i2c address low bit follows strap level
// - host keeps strap steady in i2c mode
// - software sets both config enables to one
// - serial mode samples data on clock rise
// - serial mode writes only, never drives data
// - serial first byte must be chip address
// - second byte pointer, third byte register write
// - pointer steps after each byte when flagged
// - start and stop are data edges, clock high
// - first i2c byte is address plus direction
// - answer only own i2c address with strap
// - i2c write: pointer byte then register data
// - i2c read sends pointed register, steps pointer
// - every i2c byte gets one acknowledge bit
// - host loads pointer by aborted write first
// - software leaves reserved registers at default
// - port runs unrelated to other clocks
// - pointer byte msb is the step flag
// - i2c registers read/write, serial write only
//
// Our own choices: the register addresses and the plain strobed port.
module cpp_device (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // link pins
    cpp_link_if.dev          link,
    // user side
    input  wire logic [4:0]  cfg_rd_addr,
    output logic      [7:0]  cfg_rd_data,
    output logic             config_enable_first,
    output logic             config_enable_second,
    output logic             spi_mode
);
    typedef logic [cpp_pkg::REG_COUNT-1:0][7:0] cpp_regs_t;

    typedef struct packed {
        logic [2:0]              s_strap;
        logic [2:0]              s_clk;
        logic [2:0]              s_dat;
        logic                    spi_mode;
        cpp_pkg::cpp_dev_state_t state;
        logic [3:0]              bitcnt;
        logic [1:0]              bytecnt;
        logic [7:0]              shift;
        logic                    rw;
        logic                    step;
        logic [6:0]              ptr;
        logic                    ack_pend;
        logic                    sda_out;
        logic                    sda_oe;
        cpp_regs_t               regs;
        logic [7:0]              rd_data;
        logic                    en1;
        logic                    en2;
    } cpp_dev_reg_t;

    // clock and data syncs start at the idle level, no false edge on release
    localparam cpp_dev_reg_t RST = '{state: cpp_pkg::D_IDLE, s_clk: '1,
                                     s_dat: '1, default: '0};

    cpp_dev_reg_t r;
    cpp_dev_reg_t next_r;

    function automatic logic reg_hit(input logic [6:0] p);
        reg_hit = (p < 7'(cpp_pkg::REG_COUNT));
    endfunction

    function automatic logic [7:0] reg_read(input cpp_regs_t regs,
                                            input logic [6:0] p);
        reg_read = reg_hit(p) ? regs[p[cpp_pkg::REG_AW-1:0]] : 8'h00;
    endfunction

    always_comb begin
        logic       strap_fall;
        logic       clk_rise;
        logic       clk_fall;
        logic       dat;
        logic       start;
        logic       stop;
        logic       got;
        logic       load;
        logic [7:0] gb;
        next_r = r;
        got    = 1'b0;
        load   = 1'b0;
        // pins pass two flops before use; index 0 is read only by index 1
        next_r.s_strap = {r.s_strap[1:0], link.address_select_strap};
        next_r.s_clk   = {r.s_clk[1:0], link.serial_bit_clock};
        next_r.s_dat   = {r.s_dat[1:0], link.serial_data_in};
        strap_fall = r.s_strap[2] & ~r.s_strap[1];
        clk_rise   = r.s_clk[1] & ~r.s_clk[2];
        clk_fall   = ~r.s_clk[1] & r.s_clk[2];
        dat        = r.s_dat[1];
        start      = r.s_clk[1] & r.s_clk[2] & r.s_dat[2] & ~r.s_dat[1];
        stop       = r.s_clk[1] & r.s_clk[2] & ~r.s_dat[2] & r.s_dat[1];
        gb         = {r.shift[6:0], dat};

        if (strap_fall) begin
            next_r.spi_mode = 1'b1;
        end

        if (r.spi_mode || strap_fall) begin
            next_r.sda_oe = 1'b0;
            if (strap_fall) begin
                next_r.state   = cpp_pkg::D_RECV;
                next_r.bitcnt  = '0;
                next_r.bytecnt = cpp_pkg::BYTE_ADDR;
            end else if (r.s_strap[1]) begin
                next_r.state = cpp_pkg::D_IDLE;
            end else if (clk_rise && r.state == cpp_pkg::D_RECV) begin
                next_r.shift  = gb;
                next_r.bitcnt = r.bitcnt + 4'h1;
                if (r.bitcnt == cpp_pkg::BIT_LAST_BYTE) begin
                    next_r.bitcnt = '0;
                    got           = 1'b1;
                end
            end
        end else if (start) begin
            // a start is honoured in any state, even mid-byte
            next_r.state    = cpp_pkg::D_RECV;
            next_r.bitcnt   = '0;
            next_r.bytecnt  = cpp_pkg::BYTE_ADDR;
            next_r.ack_pend = 1'b0;
            next_r.rw       = 1'b0;
            next_r.sda_oe   = 1'b0;
        end else if (stop) begin
            next_r.state    = cpp_pkg::D_IDLE;
            next_r.ack_pend = 1'b0;
            next_r.sda_oe   = 1'b0;
        end else begin
            unique case (r.state)
                cpp_pkg::D_IDLE, cpp_pkg::D_IGNORE: begin
                    next_r.sda_oe = 1'b0;
                end
                cpp_pkg::D_RECV: begin
                    if (clk_rise) begin
                        next_r.shift  = gb;
                        next_r.bitcnt = r.bitcnt + 4'h1;
                        if (r.bitcnt == cpp_pkg::BIT_LAST_BYTE) begin
                            next_r.bitcnt   = '0;
                            next_r.ack_pend = 1'b1;
                            got             = 1'b1;
                        end
                    end else if (clk_fall && r.ack_pend) begin
                        next_r.ack_pend = 1'b0;
                        next_r.sda_oe   = 1'b1;
                        next_r.state    = cpp_pkg::D_ACK;
                    end
                end
                cpp_pkg::D_ACK: begin
                    if (clk_fall) begin
                        next_r.sda_oe = 1'b0;
                        if (r.rw) begin
                            load = 1'b1;
                        end else begin
                            next_r.state = cpp_pkg::D_RECV;
                        end
                    end
                end
                cpp_pkg::D_SEND: begin
                    if (clk_fall) begin
                        if (r.bitcnt == cpp_pkg::BIT_LAST_BYTE) begin
                            next_r.sda_oe = 1'b0;
                            next_r.state  = cpp_pkg::D_HACK;
                        end else begin
                            next_r.bitcnt = r.bitcnt + 4'h1;
                            next_r.shift  = {r.shift[6:0], 1'b0};
                            next_r.sda_oe = ~r.shift[6];
                        end
                    end
                end
                cpp_pkg::D_HACK: begin
                    // a high acknowledge ends the read until the next start
                    if (clk_rise && dat) begin
                        next_r.state = cpp_pkg::D_IGNORE;
                    end else if (clk_fall) begin
                        load = 1'b1;
                    end
                end
            endcase
        end

        if (got) begin
            if (r.bytecnt == cpp_pkg::BYTE_ADDR) begin
                if (next_r.spi_mode) begin
                    if (gb != cpp_pkg::SPI_CHIP_ADDR) begin
                        next_r.state = cpp_pkg::D_IGNORE;
                    end
                end else if (gb[7:1] != {cpp_pkg::I2C_ADDR_HI,
                                         r.s_strap[1]}) begin
                    next_r.state    = cpp_pkg::D_IGNORE;
                    next_r.ack_pend = 1'b0;
                end
                next_r.rw = gb[0] & ~next_r.spi_mode;
            end else if (r.bytecnt == cpp_pkg::BYTE_PTR) begin
                next_r.step = gb[cpp_pkg::PTR_STEP_BIT];
                next_r.ptr  = gb[cpp_pkg::PTR_STEP_BIT-1:0];
            end else begin
                // writes past the register space are acknowledged, dropped
                if (reg_hit(r.ptr)) begin
                    next_r.regs[r.ptr[cpp_pkg::REG_AW-1:0]] = gb;
                end
                if (r.step) begin
                    next_r.ptr = r.ptr + cpp_pkg::PTR_ONE;
                end
            end
            if (r.bytecnt != cpp_pkg::BYTE_DATA) begin
                next_r.bytecnt = r.bytecnt + 2'h1;
            end
        end

        if (load) begin
            next_r.shift  = reg_read(r.regs, r.ptr);
            next_r.sda_oe = ~next_r.shift[7];
            next_r.bitcnt = '0;
            next_r.state  = cpp_pkg::D_SEND;
            if (r.step) begin
                next_r.ptr = r.ptr + cpp_pkg::PTR_ONE;
            end
        end

        next_r.sda_out = 1'b0;
        next_r.en1     = next_r.regs[cpp_pkg::CFG1_ADDR][cpp_pkg::EN_BIT];
        next_r.en2     = next_r.regs[cpp_pkg::GLOBAL_ADDR][cpp_pkg::EN_BIT];
        next_r.rd_data = r.regs[cfg_rd_addr];
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r <= RST;
        end else begin
            r <= next_r;
        end
    end

    assign link.dev_data_out    = r.sda_out;
    assign link.dev_data_oe     = r.sda_oe;
    assign cfg_rd_data          = r.rd_data;
    assign config_enable_first  = r.en1;
    assign config_enable_second = r.en2;
    assign spi_mode             = r.spi_mode;
endmodule

//--- core/cpp_host.sv
module cpp_host (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // link pins
    cpp_link_if.host         link,
    // command port
    input  wire logic [1:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata
);
    typedef struct packed {
        logic [1:0]               s_sda;
        logic                     ctrl_spi;
        logic                     ctrl_strap;
        logic [7:0]               ptr;
        logic [7:0]               data;
        logic [7:0]               result;
        logic                     busy;
        logic                     nack;
        logic                     is_read;
        logic                     restart;
        cpp_pkg::cpp_host_state_t state;
        logic [3:0]               tick;
        logic [1:0]               q;
        logic [3:0]               bitn;
        logic [1:0]               seq;
        logic [8:0]               tx;
        logic [8:0]               rx;
        logic                     scl;
        logic                     strap;
        logic                     sda_out;
        logic                     sda_oe;
        logic [7:0]               bus_rdata;
    } cpp_host_reg_t;

    // strap leaves reset low: a high reset level would fall at once and
    // push the device into serial mode for good
    localparam cpp_host_reg_t RST = '{state: cpp_pkg::H_IDLE, scl: 1'b1,
                                      strap: 1'b0, default: '0};

    cpp_host_reg_t r;
    cpp_host_reg_t next_r;

    function automatic logic [8:0] frame(input cpp_host_reg_t s,
                                         input logic [1:0] seq);
        logic [7:0] b;
        b = s.data;
        if (seq == cpp_pkg::BYTE_ADDR) begin
            b = s.ctrl_spi ? cpp_pkg::SPI_CHIP_ADDR
                           : {cpp_pkg::I2C_ADDR_HI, s.ctrl_strap, 1'b0};
        end else if (seq == cpp_pkg::BYTE_PTR) begin
            b = s.ptr;
        end else if (seq == cpp_pkg::BYTE_DATA && s.is_read) begin
            b = {cpp_pkg::I2C_ADDR_HI, s.ctrl_strap, 1'b1};
        end else if (seq == cpp_pkg::BYTE_READ) begin
            b = 8'hFF;
        end
        // trailing one releases the line for the acknowledge slot
        frame = {b, 1'b1};
    endfunction

    always_comb begin
        logic qstep;
        logic [3:0] last;
        next_r = r;
        next_r.s_sda     = {r.s_sda[0], link.serial_data_in};
        next_r.bus_rdata = '0;
        qstep = (r.tick == cpp_pkg::QUARTER_LAST);
        last  = r.ctrl_spi ? cpp_pkg::BIT_LAST_BYTE : cpp_pkg::BIT_LAST_I2C;

        if (rd) begin
            unique case (addr)
                cpp_pkg::HR_CTRL: next_r.bus_rdata = {6'h00, r.ctrl_strap,
                                                      r.ctrl_spi};
                cpp_pkg::HR_PTR:  next_r.bus_rdata = r.ptr;
                cpp_pkg::HR_DATA: next_r.bus_rdata = r.result;
                cpp_pkg::HR_CMD:  next_r.bus_rdata = {6'h00, r.nack, r.busy};
            endcase
        end
        // settings are frozen while a transfer runs
        if (wr && !r.busy) begin
            unique case (addr)
                cpp_pkg::HR_CTRL: begin
                    next_r.ctrl_spi   = wdata[cpp_pkg::CTRL_SPI];
                    next_r.ctrl_strap = wdata[cpp_pkg::CTRL_STRAP];
                end
                cpp_pkg::HR_PTR:  next_r.ptr  = wdata;
                cpp_pkg::HR_DATA: next_r.data = wdata;
                cpp_pkg::HR_CMD: begin
                    if (wdata[cpp_pkg::CMD_WRITE] ||
                        (wdata[cpp_pkg::CMD_READ] && !r.ctrl_spi)) begin
                        next_r.is_read = ~wdata[cpp_pkg::CMD_WRITE];
                        next_r.busy    = 1'b1;
                        next_r.nack    = 1'b0;
                        next_r.state   = cpp_pkg::H_START;
                        next_r.seq     = cpp_pkg::BYTE_ADDR;
                        next_r.q       = '0;
                        next_r.tick    = '0;
                    end
                end
            endcase
        end

        if (r.busy) begin
            next_r.tick = qstep ? 4'h0 : r.tick + 4'h1;
            if (qstep) begin
                next_r.q = r.q + 2'h1;
            end
        end

        unique case (r.state)
            cpp_pkg::H_IDLE: begin
                // strap level is steady whenever i2c is in use
                next_r.strap = r.ctrl_spi | r.ctrl_strap;
                next_r.scl   = 1'b1;
            end
            cpp_pkg::H_START: begin
                if (qstep && r.q == 2'h0) begin
                    if (r.ctrl_spi) begin
                        next_r.strap = 1'b0;
                    end else begin
                        next_r.sda_out = 1'b0;
                        next_r.sda_oe  = 1'b1;
                    end
                end else if (qstep && r.q == 2'h1) begin
                    next_r.scl = 1'b0;
                end else if (qstep && r.q == 2'h3) begin
                    next_r.state = cpp_pkg::H_BIT;
                    next_r.tx    = frame(r, r.seq);
                    next_r.bitn  = '0;
                end
            end
            cpp_pkg::H_BIT: begin
                if (qstep && r.q == 2'h0) begin
                    // data moves only while the clock is low
                    next_r.sda_out = r.ctrl_spi ? r.tx[8] : 1'b0;
                    next_r.sda_oe  = r.ctrl_spi | ~r.tx[8];
                end else if (qstep && r.q == 2'h1) begin
                    next_r.scl = 1'b1;
                end else if (qstep && r.q == 2'h2) begin
                    next_r.rx = {r.rx[7:0], r.s_sda[1]};
                end else if (qstep && r.q == 2'h3) begin
                    next_r.scl  = 1'b0;
                    next_r.tx   = {r.tx[7:0], 1'b1};
                    next_r.bitn = r.bitn + 4'h1;
                    if (r.bitn == last) begin
                        next_r.bitn = '0;
                        next_r.seq  = r.seq + 2'h1;
                        next_r.tx   = frame(r, r.seq + 2'h1);
                        if (!r.ctrl_spi && r.seq != cpp_pkg::BYTE_READ
                            && r.rx[0]) begin
                            next_r.nack  = 1'b1;
                            next_r.state = cpp_pkg::H_STOP;
                        end else if (r.seq == cpp_pkg::BYTE_READ) begin
                            next_r.result = r.rx[8:1];
                            next_r.state  = cpp_pkg::H_STOP;
                        end else if (r.is_read
                                     && r.seq == cpp_pkg::BYTE_PTR) begin
                            next_r.restart = 1'b1;
                            next_r.state   = cpp_pkg::H_STOP;
                        end else if (!r.is_read
                                     && r.seq == cpp_pkg::BYTE_DATA) begin
                            next_r.state = cpp_pkg::H_STOP;
                        end
                    end
                end
            end
            cpp_pkg::H_STOP: begin
                if (qstep && r.q == 2'h0) begin
                    next_r.sda_out = 1'b0;
                    next_r.sda_oe  = 1'b1;
                end else if (qstep && r.q == 2'h1) begin
                    next_r.scl = 1'b1;
                end else if (qstep && r.q == 2'h2) begin
                    next_r.strap  = r.ctrl_spi | r.ctrl_strap;
                    next_r.sda_oe = r.ctrl_spi;
                    next_r.sda_out = 1'b1;
                end else if (qstep && r.q == 2'h3) begin
                    if (r.restart) begin
                        next_r.restart = 1'b0;
                        next_r.seq     = cpp_pkg::BYTE_DATA;
                        next_r.state   = cpp_pkg::H_START;
                    end else begin
                        next_r.busy  = 1'b0;
                        next_r.state = cpp_pkg::H_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r <= RST;
        end else begin
            r <= next_r;
        end
    end

    assign link.address_select_strap = r.strap;
    assign link.serial_bit_clock     = r.scl;
    assign link.host_data_out        = r.sda_out;
    assign link.host_data_oe         = r.sda_oe;
    assign rdata                     = r.bus_rdata;
endmodule

//--- test/cpp_link_asserts.sv
module cpp_link_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // link wires
    input wire logic address_select_strap,
    input wire logic serial_bit_clock,
    input wire logic host_data_out,
    input wire logic host_data_oe,
    input wire logic dev_data_out,
    input wire logic dev_data_oe,
    input wire logic serial_data_in
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    dev_out_low_a: assert property (dev_data_oe |-> !dev_data_out)
        else $error("device drives data high");
    serial_no_drive_a: assert property (
        !address_select_strap |-> !dev_data_oe) else $error("serial drive");
    ack_edge_a: assert property (
        $rose(dev_data_oe) |-> !serial_bit_clock [*8])
        else $error("device data change with clock high");
    ack_hold_a: assert property (
        $rose(dev_data_oe) |-> dev_data_oe [*8] ##[1:400] !dev_data_oe)
        else $error("device drive length wrong");
    clk_idle_a: assert property (
        $fell(serial_bit_clock) |-> ##[1:40] serial_bit_clock)
        else $error("bit clock stuck low");
    sample_stable_a: assert property (
        $rose(serial_bit_clock) && !address_select_strap
        |-> ##1 $stable(serial_data_in) [*4]) else $error("data moved");
    start_by_host_a: assert property (
        $fell(serial_data_in) && serial_bit_clock && $past(serial_bit_clock)
        |-> host_data_oe) else $error("start not from host");
    select_idle_a: assert property (
        $fell(address_select_strap) |-> serial_bit_clock)
        else $error("select fell with clock low");
    no_contention_a: assert property (
        host_data_oe && dev_data_oe |-> !host_data_out)
        else $error("host drives high against device");

    cover property ($rose(dev_data_oe));
    cover property ($fell(address_select_strap));
    cover property ($rose(serial_bit_clock) && !address_select_strap);
endmodule

//--- test/dual_mode_register_control_port_tb.sv
module dual_mode_register_control_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk;
    logic       rstn;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [4:0] cfg_rd_addr;
    logic [7:0] cfg_rd_data;
    logic       config_enable_first;
    logic       config_enable_second;
    logic       spi_mode;
    int         err_count = 0;
    int         cmp_count = 0;
    int         cycles    = 0;

    cpp_link_if link ();
    cpp_device i_cpp_device (.mclk(mclk), .rstn(rstn), .link(link),
        .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data),
        .config_enable_first(config_enable_first),
        .config_enable_second(config_enable_second), .spi_mode(spi_mode));
    cpp_host i_cpp_host (.mclk(mclk), .rstn(rstn), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    cpp_link_asserts i_chk (.mclk(mclk), .rstn(rstn),
        .address_select_strap(link.address_select_strap),
        .serial_bit_clock(link.serial_bit_clock),
        .host_data_out(link.host_data_out), .host_data_oe(link.host_data_oe),
        .dev_data_out(link.dev_data_out), .dev_data_oe(link.dev_data_oe),
        .serial_data_in(link.serial_data_in));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task end_of_test;
        $display("compares %0d, errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task check8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    // start a transfer, poll busy, expect no nack
    task run_cmd(input logic [7:0] c);
        logic [7:0] s;
        int         n;
        wr_reg(cpp_pkg::HR_CMD, c);
        n = 0;
        do begin
            rd_reg(cpp_pkg::HR_CMD, s);
            n++;
        end while (s[cpp_pkg::STAT_BUSY] !== 1'b0 && n < 5000);
        check8({6'h00, s[1:0]}, 8'h00);
    endtask

    task dev_reg(input logic [4:0] a, input logic [7:0] exp);
        @(posedge mclk);
        cfg_rd_addr <= a;
        repeat (2) @(posedge mclk);
        #1 check8(cfg_rd_data, exp);
    endtask

    task send(input logic [7:0] ptr, input logic [7:0] d);
        wr_reg(cpp_pkg::HR_PTR, ptr);
        wr_reg(cpp_pkg::HR_DATA, d);
        run_cmd(8'h01);
    endtask

    task t_i2c_write;
        wr_reg(cpp_pkg::HR_CTRL, 8'h02);
        send(8'h03, 8'h01);
        dev_reg(cpp_pkg::CFG1_ADDR, 8'h01);
        send(8'h85, 8'h01);
        dev_reg(cpp_pkg::GLOBAL_ADDR, 8'h01);
        check8({6'h00, config_enable_first, config_enable_second}, 8'h03);
        $display("i2c write test done");
    endtask

    task t_i2c_read;
        logic [7:0] d;
        wr_reg(cpp_pkg::HR_PTR, 8'h05);
        run_cmd(8'h02);
        rd_reg(cpp_pkg::HR_DATA, d);
        check8(d, 8'h01);
        // 0x23 lies past the space, so the read returns 0x00
        wr_reg(cpp_pkg::HR_PTR, 8'hA3);
        run_cmd(8'h02);
        rd_reg(cpp_pkg::HR_DATA, d);
        check8(d, 8'h00);
        $display("i2c read test done");
    endtask

    task t_serial;
        wr_reg(cpp_pkg::HR_CTRL, 8'h01);
        send(8'h07, 8'hA5);
        dev_reg(5'h07, 8'hA5);
        check8({7'h00, spi_mode}, 8'h01);
        run_cmd(8'h02);
        send(8'h03, 8'h00);
        check8({7'h00, config_enable_first}, 8'h00);
        $display("serial write test done");
    endtask

    // hang guard, a few transfers need well under this
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count = err_count + 1;
            end_of_test;
        end
    end

    initial begin
        rstn        = 1'b0;
        addr        = 2'h0;
        wdata       = 8'h00;
        wr          = 1'b0;
        rd          = 1'b0;
        cfg_rd_addr = 5'h00;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        t_i2c_write;
        t_i2c_read;
        t_serial;
        end_of_test;
    end
endmodule
